/* File: logic/mws_watchdog.sv */
module mws_watchdog #(
   parameter longint unsigned TIMEOUT_CYC = mws_pkg::TIMEOUT_TYP_CYC,
   parameter bit ENABLE_LINK = 1'b1,
   parameter bit ROUTE_TO_RESET = 1'b0
) (
   input wire logic clk_sys, // system clock, 200 MHz
   input wire logic rst_b, // async reset, active low
   input wire logic watchdog_kick_input, // kick pin from supervising logic
   input wire logic ext_reset_n, // external master reset request, active low
   output logic timeout_output_n, // timeout output, active low
   output logic master_reset_n, // module master reset, active low
   output logic armed // watchdog supervising
);
   // ------------------------------------------------------------
   // kick edge detection
   // ------------------------------------------------------------
   mws_kick_if kick ();

   mws_kick_sync u_sync (
      .clk_sys(clk_sys),
      .rst_b(rst_b),
      .kick_pin(watchdog_kick_input),
      .kick(kick)
   );

   // ------------------------------------------------------------
   // constants
   // ------------------------------------------------------------
   // the register stage after the counter adds the last cycle of the interval
   localparam logic [mws_pkg::CNT_W-1:0] LAST = (mws_pkg::CNT_W)'(TIMEOUT_CYC - 1);
   localparam logic [mws_pkg::CNT_W-1:0] PULSE_LAST = (mws_pkg::CNT_W)'(mws_pkg::PULSE_CYC - 1);
   localparam logic [mws_pkg::CNT_W-1:0] CNT_ONE = (mws_pkg::CNT_W)'(1);

   typedef enum logic [1:0] {ST_DORMANT, ST_RUN, ST_PULSE} mws_state_e;

   // ------------------------------------------------------------
   // declarations
   // ------------------------------------------------------------
   mws_state_e state_reg;
   mws_state_e state_next;
   logic [mws_pkg::CNT_W-1:0] cnt_reg;
   logic [mws_pkg::CNT_W-1:0] cnt_next;
   logic [mws_pkg::CNT_W-1:0] pcnt_reg;
   logic [mws_pkg::CNT_W-1:0] pcnt_next;
   logic wdo_reg;
   logic wdo_next;
   logic supervising; // kicks and timeouts count
   logic in_pulse; // timeout output is being held low
   logic kick_hit; // accepted kick edge
   logic interval_end; // a whole interval passed with no kick
   logic pulse_end; // last low cycle of the timeout pulse

   // ------------------------------------------------------------
   // event decode
   // ------------------------------------------------------------
   always_comb
   begin
      supervising = (state_reg != ST_DORMANT);
      in_pulse = (state_reg == ST_PULSE);
      kick_hit = kick.edge_seen;
      // a kick in the last cycle of an interval wins, so no pulse follows
      interval_end = supervising && !kick_hit && (cnt_reg == LAST);
      pulse_end = in_pulse && (pcnt_reg == PULSE_LAST);
   end

   // ------------------------------------------------------------
   // supervision state
   // ------------------------------------------------------------
   always_comb
   begin
      state_next = state_reg;
      case (state_reg)
         ST_DORMANT:
         begin
            // a floating pin shows no edges, so supervision never starts
            if (ENABLE_LINK && kick_hit)
            begin
               state_next = ST_RUN;
            end
         end
         ST_RUN:
         begin
            if (interval_end)
            begin
               state_next = ST_PULSE;
            end
         end
         ST_PULSE:
         begin
            // an interval that ends inside the pulse starts a fresh pulse
            if (interval_end)
            begin
               state_next = ST_PULSE;
            end
            else if (pulse_end)
            begin
               state_next = ST_RUN;
            end
         end
         default:
         begin
            state_next = ST_DORMANT;
         end
      endcase
   end

   always_ff @(posedge clk_sys or negedge rst_b)
   begin
      if (!rst_b)
      begin
         state_reg <= ST_DORMANT;
      end
      else
      begin
         state_reg <= state_next;
      end
   end

   // ------------------------------------------------------------
   // interval counter
   // ------------------------------------------------------------
   always_comb
   begin
      cnt_next = cnt_reg;
      if (!supervising)
      begin
         cnt_next = '0;
      end
      else if (kick_hit)
      begin
         cnt_next = '0;
      end
      else if (interval_end)
      begin
         // timer restarts while the pulse is still low
         cnt_next = '0;
      end
      else
      begin
         cnt_next = cnt_reg + CNT_ONE;
      end
   end

   always_ff @(posedge clk_sys or negedge rst_b)
   begin
      if (!rst_b)
      begin
         cnt_reg <= '0;
      end
      else
      begin
         cnt_reg <= cnt_next;
      end
   end

   // ------------------------------------------------------------
   // timeout pulse length
   // ------------------------------------------------------------
   always_comb
   begin
      pcnt_next = pcnt_reg;
      if (interval_end)
      begin
         pcnt_next = '0;
      end
      else if (in_pulse && !pulse_end)
      begin
         pcnt_next = pcnt_reg + CNT_ONE;
      end
   end

   always_ff @(posedge clk_sys or negedge rst_b)
   begin
      if (!rst_b)
      begin
         pcnt_reg <= '0;
      end
      else
      begin
         pcnt_reg <= pcnt_next;
      end
   end

   // ------------------------------------------------------------
   // timeout output register
   // ------------------------------------------------------------
   always_comb
   begin
      // inactive high unless an interval has just ended or a pulse runs on
      wdo_next = 1'h1;
      if (interval_end)
      begin
         wdo_next = 1'h0;
      end
      else if (in_pulse && !pulse_end)
      begin
         wdo_next = 1'h0;
      end
   end

   always_ff @(posedge clk_sys or negedge rst_b)
   begin
      if (!rst_b)
      begin
         wdo_reg <= mws_pkg::TIMEOUT_RST;
      end
      else
      begin
         wdo_reg <= wdo_next;
      end
   end

   // ------------------------------------------------------------
   // outputs and build routing
   // ------------------------------------------------------------
   assign timeout_output_n = wdo_reg;
   assign armed = supervising;
   // the pin request is ignored once the timeout owns the reset line
   assign master_reset_n = ROUTE_TO_RESET ? wdo_reg : ext_reset_n;
endmodule : mws_watchdog

/* File: common/mws_pkg.sv */
package mws_pkg;
   // ------------------------------------------------------------
   // timing
   // ------------------------------------------------------------
   localparam int unsigned CLK_HZ = 200_000_000;
   // timeout interval in milliseconds: least, typical, most
   localparam int unsigned TIMEOUT_MIN_MS = 1100;
   localparam int unsigned TIMEOUT_TYP_MS = 1600;
   localparam int unsigned TIMEOUT_MAX_MS = 2300;
   localparam longint unsigned TIMEOUT_TYP_CYC = longint'(TIMEOUT_TYP_MS) * CLK_HZ / 1000;
   localparam int unsigned CNT_W = 32;
   // width of the low pulse on the timeout output
   localparam int unsigned PULSE_US = 1;
   localparam int unsigned PULSE_CYC = PULSE_US * (CLK_HZ / 1_000_000);
   // synchroniser depth for the kick pin
   localparam int unsigned SYNC_STAGES = 3;
   // reset value of the timeout output (inactive, high)
   localparam logic TIMEOUT_RST = 1'b1;
endpackage : mws_pkg

/* File: common/mws_kick_if.sv */
interface mws_kick_if;
   logic edge_seen; // one-cycle pulse on each filtered kick edge
   logic level;     // filtered kick level
   modport src (output edge_seen, output level);
   modport dst (input edge_seen, input level);
endinterface : mws_kick_if

/* File: logic/mws_kick_sync.sv */
module mws_kick_sync (
   input wire logic clk_sys, // system clock
   input wire logic rst_b, // async reset, active low
   input wire logic kick_pin, // raw kick pin
   mws_kick_if.src kick // filtered kick events
);
   logic [2:0] sync_reg;
   logic [2:0] sync_next;
   logic level_reg;
   logic level_next;
   logic edge_reg;
   logic edge_next;

   always_comb
   begin
      sync_next = {sync_reg[1:0], kick_pin};
      level_next = level_reg;
      edge_next = 1'b0;
      // a change counts only once stages two and three agree
      if ((sync_reg[2] == sync_reg[1]) && (sync_reg[2] != level_reg))
      begin
         level_next = sync_reg[2];
         edge_next = 1'b1;
      end
   end

   always_ff @(posedge clk_sys or negedge rst_b)
   begin
      if (!rst_b)
      begin
         sync_reg <= 3'h0;
         level_reg <= 1'b0;
         edge_reg <= 1'b0;
      end
      else
      begin
         sync_reg <= sync_next;
         level_reg <= level_next;
         edge_reg <= edge_next;
      end
   end

   assign kick.edge_seen = edge_reg;
   assign kick.level = level_reg;
endmodule : mws_kick_sync

/* File: dv/mws_watchdog_chk.sv */
module mws_watchdog_chk #(
   parameter longint unsigned TIMEOUT_CYC = 100,
   parameter bit ENABLE_LINK = 1'b1,
   parameter bit ROUTE_TO_RESET = 1'b0
) (
   input wire logic clk_sys, // clock
   input wire logic rst_b, // reset
   input wire logic watchdog_kick_input, // kick
   input wire logic ext_reset_n, // reset in
   input wire logic timeout_output_n, // timeout
   input wire logic master_reset_n, // reset out
   input wire logic armed // armed
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking @(posedge clk_sys);
   endclocking
   default disable iff (!rst_b);
   logic kick_reg;
   logic [31:0] idle_reg;
   logic [31:0] low_reg;
   wire logic chg = kick_reg != watchdog_kick_input;
   // cycles since the last pin change or timeout, and cycles held low
   always_ff @(posedge clk_sys or negedge rst_b)
   begin
      if (!rst_b)
         {kick_reg, idle_reg, low_reg} <= '0;
      else
      begin
         kick_reg <= watchdog_kick_input;
         // a fall is seen one cycle late, so the new interval already holds one cycle
         idle_reg <= chg ? 32'h0 : $fell(timeout_output_n) ? 32'h1 : idle_reg + 32'h1;
         low_reg <= timeout_output_n ? 32'h0 : low_reg + 32'h1;
      end
   end
   AST_OFF: assert property (!ENABLE_LINK |-> !armed && timeout_output_n)
      else $error("active without link");
   AST_DORMANT: assert property (!armed |-> timeout_output_n)
      else $error("timeout while dormant");
   AST_ARM: assert property (ENABLE_LINK && chg |-> ##[1:8] armed)
      else $error("kick did not arm");
   AST_STD: assert property (!ROUTE_TO_RESET |-> master_reset_n == ext_reset_n)
      else $error("reset not from pin");
   AST_ALT: assert property (ROUTE_TO_RESET |-> master_reset_n == timeout_output_n)
      else $error("reset not from timeout");
   AST_PULSE: assert property ($fell(timeout_output_n) |=> !timeout_output_n [*8])
      else $error("pulse too short");
   AST_WIDTH: assert property ($rose(timeout_output_n) |-> low_reg == mws_pkg::PULSE_CYC)
      else $error("pulse width wrong");
   AST_HOLD: assert property ($fell(timeout_output_n) |-> idle_reg >= TIMEOUT_CYC)
      else $error("timeout too early");
   AST_PERIOD: assert property (armed |-> idle_reg <= TIMEOUT_CYC + 8)
      else $error("timeout missing");
   cover property ($fell(timeout_output_n));
   cover property ($rose(armed));
   cover property (chg && !timeout_output_n);
endmodule : mws_watchdog_chk

bind mws_watchdog mws_watchdog_chk #(.TIMEOUT_CYC(TIMEOUT_CYC), .ENABLE_LINK(ENABLE_LINK),
   .ROUTE_TO_RESET(ROUTE_TO_RESET)) chk (.clk_sys(clk_sys), .rst_b(rst_b),
   .watchdog_kick_input(watchdog_kick_input), .ext_reset_n(ext_reset_n),
   .timeout_output_n(timeout_output_n), .master_reset_n(master_reset_n), .armed(armed));

/* File: dv/mws_kicker.sv */
module mws_kicker (
   input wire logic clk_sys, // clock
   input wire logic run, // toggle when high
   output logic kick // kick pin
);
   timeunit 1ns;
   timeprecision 1ps;
   int n = 0;
   initial kick = 1'b0;
   // idle pin holds still: a floating pin must show no edges
   always @(posedge clk_sys)
   begin
      n <= run ? (n + 1) % 100 : 0;
      if (run && n == 99)
         kick <= ~kick;
   end
endmodule : mws_kicker

/* File: dv/mws_watchdog_supervisor_test.sv */
module mws_watchdog_supervisor_test;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int TO = 300;
   logic clk_sys = 1'b0, rst_b = 1'b0, ext_reset_n = 1'b1, run = 1'b0, kick;
   wire [2:0] wdo, mr, arm;
   logic [2:0] low;
   int n_mismatch = 0, cmp_count = 0, k1, k2;
   initial forever #2.5 clk_sys = ~clk_sys;
   mws_kicker kicker (.clk_sys(clk_sys), .run(run), .kick(kick));
   for (genvar i = 0; i < 3; i++)
   begin : g
      mws_watchdog #(.TIMEOUT_CYC(TO), .ENABLE_LINK(i != 1), .ROUTE_TO_RESET(i == 2)) dut (
         .clk_sys(clk_sys), .rst_b(rst_b), .watchdog_kick_input(kick),
         .ext_reset_n(i == 2 ? 1'b1 : ext_reset_n),
         .timeout_output_n(wdo[i]), .master_reset_n(mr[i]),
         .armed(arm[i]));
   end
   task automatic check(input string nm, input logic [5:0] got, input logic [5:0] exp);
      cmp_count++;
      if (got !== exp)
      begin
         n_mismatch++;
         $display("[FAIL] %s expected %h seen %h", nm, exp, got);
      end
   endtask : check
   task automatic end_sim();
      if (n_mismatch == 0 && cmp_count > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask : end_sim
   task automatic wait_lvl(input logic v, output int k);
      k = 0;
      while (wdo[0] !== v)
      begin
         @(posedge clk_sys);
         k++;
         if (k > TO + 20)
         begin
            n_mismatch++;
            end_sim();
         end
      end
   endtask : wait_lvl
   task automatic t_kicked();
      low = 3'h0;
      run <= 1'b1;
      repeat (3 * TO)
      begin
         @(posedge clk_sys);
         low = low | ~wdo;
      end
      check("armed", arm, 3'h5);
      check("low seen", low, 3'h0);
      check("master reset idle", mr, 3'h7);
   endtask : t_kicked
   task automatic t_timeout();
      run <= 1'b0;
      ext_reset_n <= 1'b0;
      wait_lvl(1'b0, k1);
      check("master reset", mr, 3'h0);
      wait_lvl(1'b1, k1);
      wait_lvl(1'b0, k2);
      check("pulse", 3'(k1 == int'(mws_pkg::PULSE_CYC)), 3'h1);
      check("period", 3'(k1 + k2 >= TO && k1 + k2 <= TO + 1), 3'h1);
      ext_reset_n <= 1'b1;
   endtask : t_timeout
   initial
   begin
      repeat (5) @(posedge clk_sys);
      rst_b <= 1'b1;
      repeat (2 * TO) @(posedge clk_sys);
      check("dormant", {arm, wdo}, 6'h07);
      t_kicked();
      t_timeout();
      end_sim();
   end
endmodule : mws_watchdog_supervisor_test
